/* File: ldoreg_pkg.sv */
// package for the ldo channel control register bank
// assumes an 8-bit register address/data port driven by the serial interface logic
package ldoreg_pkg;
   localparam int unsigned LDOREG_NCH = 3;
   localparam logic [7:0] LDOREG_ADDR_B_VSEL = 8'h54;
   localparam logic [7:0] LDOREG_ADDR_B_CTRL = 8'h55;
   localparam logic [7:0] LDOREG_ADDR_C_VSEL = 8'h60;
   localparam logic [7:0] LDOREG_ADDR_C_CTRL = 8'h61;
   localparam logic [7:0] LDOREG_ADDR_D_VSEL = 8'h64;
   localparam logic [7:0] LDOREG_ADDR_D_CTRL = 8'h65;
   localparam int unsigned LDOREG_BIT_ENABLE = 7;
   localparam int unsigned LDOREG_BIT_DISCH = 6;
   localparam int unsigned LDOREG_BIT_LOW_QUIESCENT_MODE = 5;
   localparam int unsigned LDOREG_BIT_DELAY_LO = 2;
   localparam int unsigned LDOREG_BIT_UNMASK = 1;
   localparam int unsigned LDOREG_BIT_PGOOD = 0;
   localparam logic [5:0] LDOREG_VSEL_RST = 6'h00;
   localparam logic [2:0] LDOREG_DELAY_RST = 3'h0;
   localparam logic [5:0] LDOREG_CTRL_RST = 6'h00;
   localparam logic LDOREG_UNMASK_RST = 1'b0;
   localparam logic [7:0] LDOREG_RDATA_UNMAPPED = 8'h00;

   // register-access request from the serial interface
   typedef struct packed
   {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ldoreg_req_t;

   // per-channel control state toward the analog regulator
   typedef struct packed
   {
      logic enable;
      logic discharge_active;
      logic low_quiescent_mode;
      logic [2:0] turn_on_delay;
      logic fault_irq_unmask;
      logic [5:0] voltage_code;
   } ldoreg_chan_t;
endpackage : ldoreg_pkg

/* File: ldoreg_bank.sv */
// register bank for three ldo channels: voltage select and control per channel
// assumes requests arrive synchronous to sys_clk as single-cycle strobes
`timescale 1ns/1ps

// Function
// R1: six-bit voltage code in voltage select low bits
// R2: control bit 7 enables the channel
// R3: bit 6 enables discharge while channel shut down
// R4: bit 5 selects low-quiescent mode
// R5: bits 4:2 hold turn-on delay code
// R6: bit 1 unmasks channel fault interrupts
// R7: bit 0 is read-only power-good status
// R8: voltage select bits 7:6 read zero
module ldoreg_bank
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // register access
   input wire ldoreg_pkg::ldoreg_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   // analog channel side
   input wire logic [ldoreg_pkg::LDOREG_NCH-1:0] pgood_in,
   input wire logic [ldoreg_pkg::LDOREG_NCH-1:0] fault_in,
   output ldoreg_pkg::ldoreg_chan_t [ldoreg_pkg::LDOREG_NCH-1:0] chan,
   output logic [ldoreg_pkg::LDOREG_NCH-1:0] fault_irq_req
);
   import ldoreg_pkg::*;

   // control bits 7:2 live in ctrl_r, bit 1 in unmask_r; bit 0 is live status and never stored
   logic [5:0] vsel_r [LDOREG_NCH];
   logic [5:0] ctrl_r [LDOREG_NCH];
   logic unmask_r [LDOREG_NCH];
   logic [7:0] rdata_nxt;
   logic [LDOREG_NCH-1:0] vsel_hit;
   logic [LDOREG_NCH-1:0] ctrl_hit;

   localparam logic [7:0] VSEL_ADDR [LDOREG_NCH] = '{LDOREG_ADDR_B_VSEL, LDOREG_ADDR_C_VSEL, LDOREG_ADDR_D_VSEL};
   localparam logic [7:0] CTRL_ADDR [LDOREG_NCH] = '{LDOREG_ADDR_B_CTRL, LDOREG_ADDR_C_CTRL, LDOREG_ADDR_D_CTRL};

   genvar g;
   generate
      for (g = 0; g < LDOREG_NCH; g++)
      begin : g_ch
         assign vsel_hit[g] = (req.addr == VSEL_ADDR[g]);
         assign ctrl_hit[g] = (req.addr == CTRL_ADDR[g]);

         // upper two bits are not stored at all
         always_ff @(posedge sys_clk)
         begin
            if (srst)
               vsel_r[g] <= LDOREG_VSEL_RST;
            else if (req.wr_en && vsel_hit[g])
               vsel_r[g] <= req.wdata[5:0]; // [R1] [R8]
         end

         // ctrl_r[5] is bit 7, ctrl_r[4] bit 6, ctrl_r[3] bit 5, ctrl_r[2:0] bits 4:2
         always_ff @(posedge sys_clk)
         begin
            if (srst)
               ctrl_r[g] <= LDOREG_CTRL_RST;
            else if (req.wr_en && ctrl_hit[g])
               ctrl_r[g] <= req.wdata[7:2]; // [R2] [R3] [R4] [R5]
         end

         // kept apart from ctrl_r because the fault path reads it every cycle
         always_ff @(posedge sys_clk)
         begin
            if (srst)
               unmask_r[g] <= LDOREG_UNMASK_RST;
            else if (req.wr_en && ctrl_hit[g])
               unmask_r[g] <= req.wdata[LDOREG_BIT_UNMASK]; // [R6]
         end

         chk_disch_gated: assert property (@(posedge sys_clk) disable iff (srst)
            chan[g].discharge_active |-> !chan[g].enable) // [R3]
            else $error("discharge active while channel enabled");
         chk_fault_mask: assert property (@(posedge sys_clk) disable iff (srst)
            (!unmask_r[g] && !$past(srst)) |=> !fault_irq_req[g]) // [R6]
            else $error("masked fault raised interrupt request");
         chk_fault_pass: assert property (@(posedge sys_clk) disable iff (srst)
            (unmask_r[g] && fault_in[g]) |=> fault_irq_req[g]) // [R6]
            else $error("unmasked fault did not raise interrupt request");
         chk_unmask_write: assert property (@(posedge sys_clk) disable iff (srst)
            (req.wr_en && ctrl_hit[g]) |=> ##1 (chan[g].fault_irq_unmask == $past(req.wdata[1], 2))) // [R6]
            else $error("fault unmask not updated by write");
         chk_disch_write: assert property (@(posedge sys_clk) disable iff (srst)
            (req.wr_en && ctrl_hit[g])
            |=> ##1 (chan[g].discharge_active == ($past(req.wdata[6], 2) & !$past(req.wdata[7], 2)))) // [R3]
            else $error("discharge not updated by write");
         chk_vsel_hold: assert property (@(posedge sys_clk) disable iff (srst)
            !(req.wr_en && vsel_hit[g]) |=> (vsel_r[g] == $past(vsel_r[g]))) // [R1]
            else $error("voltage code changed without a write");
         chk_ctrl_read: assert property (@(posedge sys_clk) disable iff (srst)
            (req.rd_en && ctrl_hit[g])
            |=> (rdata == {$past(ctrl_r[g]), $past(unmask_r[g]), $past(pgood_in[g])})) // [R7]
            else $error("control register readback mismatch");
         chk_vsel_read: assert property (@(posedge sys_clk) disable iff (srst)
            (req.rd_en && vsel_hit[g]) |=> (rdata == {2'b00, $past(vsel_r[g])})) // [R1]
            else $error("voltage select readback mismatch");
         chk_vsel_write: assert property (@(posedge sys_clk) disable iff (srst)
            (req.wr_en && vsel_hit[g]) |=> ##1 (chan[g].voltage_code == $past(req.wdata[5:0], 2))) // [R1]
            else $error("voltage code not updated by write");
         chk_enable_write: assert property (@(posedge sys_clk) disable iff (srst)
            (req.wr_en && ctrl_hit[g]) |=> ##1 (chan[g].enable == $past(req.wdata[7], 2))) // [R2]
            else $error("enable not updated by write");
         chk_low_quiescent_mode_write: assert property (@(posedge sys_clk) disable iff (srst)
            (req.wr_en && ctrl_hit[g]) |=> ##1 (chan[g].low_quiescent_mode == $past(req.wdata[5], 2))) // [R4]
            else $error("low quiescent mode not updated by write");
         chk_delay_write: assert property (@(posedge sys_clk) disable iff (srst)
            (req.wr_en && ctrl_hit[g]) |=> ##1 (chan[g].turn_on_delay == $past(req.wdata[4:2], 2))) // [R5]
            else $error("turn-on delay not updated by write");
      end
   endgenerate

   // one process writes every channel output, so each output variable has a single writer
   // discharge only acts when the channel is off
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         chan <= '0;
         fault_irq_req <= '0;
      end
      else
      begin
         for (int i = 0; i < LDOREG_NCH; i++)
         begin
            chan[i].enable <= ctrl_r[i][5]; // [R2]
            chan[i].discharge_active <= ctrl_r[i][4] & ~ctrl_r[i][5]; // [R3]
            chan[i].low_quiescent_mode <= ctrl_r[i][3]; // [R4]
            chan[i].turn_on_delay <= ctrl_r[i][2:0]; // [R5]
            chan[i].fault_irq_unmask <= unmask_r[i]; // [R6]
            chan[i].voltage_code <= vsel_r[i]; // [R1]
            fault_irq_req[i] <= fault_in[i] & unmask_r[i]; // [R6]
         end
      end
   end

   // read mux; pgood is sampled live so software sees the current level
   always_comb
   begin
      rdata_nxt = LDOREG_RDATA_UNMAPPED;
      for (int i = 0; i < LDOREG_NCH; i++)
      begin
         if (vsel_hit[i])
            rdata_nxt = {2'b00, vsel_r[i]}; // [R8]
         if (ctrl_hit[i])
            rdata_nxt = {ctrl_r[i], unmask_r[i], pgood_in[i]}; // [R7]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end
      else
      begin
         rvalid <= req.rd_en;
         if (req.rd_en)
            rdata <= rdata_nxt;
      end
   end

   chk_vsel_rsvd: assert property (@(posedge sys_clk) disable iff (srst)
      (req.rd_en && |vsel_hit) |=> (rvalid && rdata[7:6] == 2'b00)) // [R8]
      else $error("reserved voltage select bits read nonzero");
   chk_pgood_read: assert property (@(posedge sys_clk) disable iff (srst)
      (req.rd_en && ctrl_hit[0]) |=> (rdata[0] == $past(pgood_in[0]))) // [R7]
      else $error("power good readback mismatch");
   chk_rvalid_pulse: assert property (@(posedge sys_clk) disable iff (srst)
      req.rd_en |=> rvalid) // [R7]
      else $error("read not answered one cycle later");
   chk_rvalid_idle: assert property (@(posedge sys_clk) disable iff (srst)
      !req.rd_en |=> !rvalid) // [R7]
      else $error("read answer without a read request");
   chk_unmapped_read: assert property (@(posedge sys_clk) disable iff (srst)
      (req.rd_en && !(|vsel_hit) && !(|ctrl_hit)) |=> (rdata == LDOREG_RDATA_UNMAPPED)) // [R8]
      else $error("unmapped read returned nonzero");
   chk_reset_quiet: assert property (@(posedge sys_clk)
      $past(srst) |-> (chan == '0 && fault_irq_req == '0 && !rvalid)) // [R2]
      else $error("outputs not cleared by reset");
endmodule : ldoreg_bank

/* File: ldoreg_host.sv */
// host model: single-cycle register reads and writes toward the bank
// assumes callers enter its task at a falling edge of sys_clk
`timescale 1ns/1ps
module ldoreg_host
(
   // clock
   input wire logic sys_clk,
   // request and answer
   output ldoreg_pkg::ldoreg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   import ldoreg_pkg::*;
   logic [7:0] last_rd;
   logic rd_ok;
   initial req = '0;
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      req = '{wr_en: wr, rd_en: !wr, addr: a, wdata: d};
      @(negedge sys_clk);
      // released lines show the inverse, so stale values never pass
      req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
      // rvalid stands only from the taking edge to the next one, so look at this falling edge first
      rd_ok = wr;
      for (n = 0; n < 4 && !rd_ok; n++)
      begin
         rd_ok = (rvalid === 1'b1);
         last_rd = rdata;
         if (!rd_ok)
            @(negedge sys_clk);
      end
      @(negedge sys_clk);
   endtask : access
endmodule : ldoreg_host

/* File: ldo_channel_control_regs_tb.sv */
// self-checking bench: random register traffic against an array model
// assumes a single 100 MHz clock and inputs driven at falling edges
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ldo_channel_control_regs_tb;
   import ldoreg_pkg::*;
   logic sys_clk = 0;
   logic srst = 1;
   logic [2:0] pgood_in = 0;
   logic [2:0] fault_in = 0;
   ldoreg_req_t req;
   logic [7:0] rdata;
   logic rvalid;
   ldoreg_chan_t [2:0] chan;
   logic [2:0] fault_irq_req;
   int err_total = 0;
   int n_checks = 0;
   int unsigned rs = 65045;
   logic [7:0] vs[3] = '{0, 0, 0};
   logic [7:0] ct[3] = '{0, 0, 0};
   logic [7:0] va[3] = '{8'h54, 8'h60, 8'h64};
   always #5 sys_clk = ~sys_clk;
   ldoreg_bank u_ldoreg_bank (.sys_clk, .srst, .req, .rdata, .rvalid, .pgood_in, .fault_in, .chan, .fault_irq_req);
   ldoreg_host u_ldoreg_host (.sys_clk, .req, .rdata, .rvalid);
   function automatic int unsigned xr();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xr
   task automatic conclude();
      $display("errors %0d checks %0d", err_total, n_checks);
      if (err_total == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      u_ldoreg_host.access(1'b0, a, 8'h00);
      if (!u_ldoreg_host.rd_ok)
      begin
         err_total++;
         conclude();
      end
      else
         `CHK(u_ldoreg_host.last_rd, exp)
   endtask : rd
   task automatic chk_ch(input int c);
      rd(va[c], {2'b00, vs[c][5:0]});
      rd(8'(va[c] + 1), {ct[c][7:1], pgood_in[c]});
      `CHK(chan[c], ldoreg_chan_t'({ct[c][7], ct[c][6] & ~ct[c][7], ct[c][5:1], vs[c][5:0]}))
      `CHK(fault_irq_req[c], fault_in[c] & ct[c][1])
   endtask : chk_ch
   initial
   begin
      int c;
      logic [7:0] d;
      repeat (5) @(negedge sys_clk);
      srst = 0;
      for (c = 0; c < 3; c++) chk_ch(c);
      // unmapped write, then a read of the same address must return zero; channels are not rechecked here
      u_ldoreg_host.access(1'b1, 8'h56, 8'hff);
      rd(8'h56, 8'h00);
      repeat (80)
      begin
         c = xr() % 3;
         d = 8'(xr());
         pgood_in = 3'(xr());
         fault_in = 3'(xr());
         if (xr() & 1)
         begin
            u_ldoreg_host.access(1'b1, 8'(va[c] + 1), d);
            ct[c] = d & 8'hfe;
         end
         else
         begin
            u_ldoreg_host.access(1'b1, va[c], d);
            vs[c] = d & 8'h3f;
         end
         chk_ch(c);
      end
      // mid-run reset must clear every register and output
      srst = 1;
      repeat (2) @(negedge sys_clk);
      srst = 0;
      for (c = 0; c < 3; c++)
      begin
         vs[c] = 0;
         ct[c] = 0;
      end
      for (c = 0; c < 3; c++) chk_ch(c);
      conclude();
   end
endmodule : ldo_channel_control_regs_tb
